// *** half_bridge_ctrl_regs.sv ***
// serial control register bank of the eight half-bridge outputs
`timescale 1ns/1ns
`default_nettype none
module half_bridge_ctrl_regs #(
	parameter int BRIDGES = hb_regs_pkg::BRIDGES
) (
	input wire logic CLOCK_I,
	input wire logic RST_I,
	input wire logic SPI_CS_N_I,
	input wire logic SPI_CLK_I,
	input wire logic SPI_DATA_I,
	output var logic SPI_DATA_O,
	output var logic SPI_DATA_OE_O,
	output var logic [BRIDGES-1:0] HIGH_SIDE_ON_O,
	output var logic [BRIDGES-1:0] LOW_SIDE_ON_O,
	output var logic [7:0] PWM_SOURCE_O
);
	generate
		if (BRIDGES != 2 * hb_regs_pkg::BRIDGES_PER_REG) begin : g_bad
			$error("two switch registers serve exactly eight bridges");
		end
	endgenerate

	logic [2:0] pins_s;
	logic cs_n_prev_reg;
	logic sclk_prev_reg;
	hb_regs_pkg::frame_state_e state_reg;
	hb_regs_pkg::frame_state_e state_next;
	logic [4:0] bit_cnt_reg;
	logic [15:0] rx_reg;
	logic [7:0] tx_reg;
	logic oe_reg;
	logic [7:0] sw_lo_reg;
	logic [7:0] sw_hi_reg;
	logic [7:0] mode_reg;
	logic [BRIDGES-1:0] high_reg;
	logic [BRIDGES-1:0] low_reg;
	logic [7:0] pwm_reg;

	pin_sync #(
		.WIDTH(3),
		.RESET_VALUE(hb_regs_pkg::PIN_RESET)
	) u_pin_sync (
		.clk_i(CLOCK_I),
		.rst_i(RST_I),
		.d_i({SPI_CS_N_I, SPI_CLK_I, SPI_DATA_I}),
		.q_o(pins_s)
	);

	wire cs_n_s = pins_s[2];
	wire sclk_s = pins_s[1];
	wire sdi_s = pins_s[0];
	wire sclk_rise = sclk_s & ~sclk_prev_reg;
	wire sclk_fall = ~sclk_s & sclk_prev_reg;
	wire cs_fall = ~cs_n_s & cs_n_prev_reg;
	wire cs_rise = cs_n_s & ~cs_n_prev_reg;
	wire in_addr = state_reg == hb_regs_pkg::ST_ADDR;
	wire in_data = state_reg == hb_regs_pkg::ST_DATA;
	wire shifting = in_addr | in_data;

	// one-hot register select from an address byte; bit 1 is don't-care
	function automatic logic [2:0] decode(input logic [7:0] a);
		logic base;
		base = a[3:2] == hb_regs_pkg::SEL_MIDDLE
			&& a[0] == hb_regs_pkg::SEL_TAG;
		decode[0] = base && a[6:4] == hb_regs_pkg::SEL_SWITCH_LOWER;
		decode[1] = base && a[6:4] == hb_regs_pkg::SEL_SWITCH_UPPER;
		decode[2] = base && a[6:4] == hb_regs_pkg::SEL_PWM_LOWER;
	endfunction

	// address arrives first: it is in the low byte as the data byte starts, and in the high byte once the frame is full
	wire [2:0] rd_sel = decode(rx_reg[7:0]);
	wire [2:0] wr_sel = decode(rx_reg[15:8]);
	wire [7:0] rd_value = ({8{rd_sel[0]}} & sw_lo_reg)
		| ({8{rd_sel[1]}} & sw_hi_reg)
		| ({8{rd_sel[2]}} & mode_reg);
	wire load_tx = sclk_fall && in_data
		&& bit_cnt_reg == hb_regs_pkg::DATA_FIRST_BIT;
	wire shift_tx = sclk_fall && in_data && !load_tx;
	// short or long frames never commit
	wire commit = cs_rise && state_reg == hb_regs_pkg::ST_FULL;
	wire wr_en = commit && rx_reg[8 + hb_regs_pkg::WRITE_FLAG_POS];
	wire [15:0] sw_all = {sw_hi_reg, sw_lo_reg};
	logic [BRIDGES-1:0] high_want;
	logic [BRIDGES-1:0] low_want;
	logic [BRIDGES-1:0] high_drive;
	logic [BRIDGES-1:0] low_drive;

	generate
		for (genvar b = 0; b < BRIDGES; b++) begin : g_bridge
			assign high_want[b] = sw_all[2*b+1];
			assign low_want[b] = sw_all[2*b];
			// both on would short the supply, so both go off
			assign high_drive[b] = high_want[b] & ~low_want[b];
			assign low_drive[b] = low_want[b] & ~high_want[b];
		end
	endgenerate

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			hb_regs_pkg::ST_IDLE: begin
				if (cs_fall)
					state_next = hb_regs_pkg::ST_ADDR;
			end
			hb_regs_pkg::ST_ADDR: begin
				if (cs_rise)
					state_next = hb_regs_pkg::ST_IDLE;
				else if (sclk_rise && bit_cnt_reg == hb_regs_pkg::ADDR_LAST_BIT)
					state_next = hb_regs_pkg::ST_DATA;
			end
			hb_regs_pkg::ST_DATA: begin
				if (cs_rise)
					state_next = hb_regs_pkg::ST_IDLE;
				else if (sclk_rise && bit_cnt_reg == hb_regs_pkg::DATA_LAST_BIT)
					state_next = hb_regs_pkg::ST_FULL;
			end
			hb_regs_pkg::ST_FULL: begin
				if (cs_rise)
					state_next = hb_regs_pkg::ST_IDLE;
				else if (sclk_rise)
					state_next = hb_regs_pkg::ST_OVER;
			end
			hb_regs_pkg::ST_OVER: begin
				if (cs_rise)
					state_next = hb_regs_pkg::ST_IDLE;
			end
			default: begin
				state_next = hb_regs_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			cs_n_prev_reg <= 1'h1;
			sclk_prev_reg <= 1'h0;
			state_reg <= hb_regs_pkg::ST_IDLE;
		end else begin
			cs_n_prev_reg <= cs_n_s;
			sclk_prev_reg <= sclk_s;
			state_reg <= state_next;
		end
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			bit_cnt_reg <= 5'h00;
			rx_reg <= 16'h0000;
		end else if (cs_fall) begin
			bit_cnt_reg <= 5'h00;
		end else if (sclk_rise && shifting) begin
			bit_cnt_reg <= bit_cnt_reg + 5'h01;
			rx_reg <= {rx_reg[14:0], sdi_s};
		end
	end

	// address byte answers zeros; the data byte returns the register
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			tx_reg <= 8'h00;
			oe_reg <= 1'h0;
		end else begin
			oe_reg <= ~cs_n_s;
			if (cs_fall)
				tx_reg <= 8'h00;
			else if (load_tx)
				tx_reg <= rd_value;
			else if (shift_tx)
				tx_reg <= {tx_reg[6:0], 1'h0};
		end
	end

	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			sw_lo_reg <= hb_regs_pkg::REG_RESET;
			sw_hi_reg <= hb_regs_pkg::REG_RESET;
			mode_reg <= hb_regs_pkg::REG_RESET;
		end else if (wr_en) begin
			if (wr_sel[0])
				sw_lo_reg <= rx_reg[7:0];
			if (wr_sel[1])
				sw_hi_reg <= rx_reg[7:0];
			if (wr_sel[2])
				mode_reg <= rx_reg[7:0];
		end
	end

	// mode fields pass through unchanged; codes 00..11 are decoded downstream
	always_ff @(posedge CLOCK_I or posedge RST_I) begin
		if (RST_I) begin
			high_reg <= '0;
			low_reg <= '0;
			pwm_reg <= hb_regs_pkg::REG_RESET;
		end else begin
			high_reg <= high_drive;
			low_reg <= low_drive;
			pwm_reg <= mode_reg;
		end
	end

	assign SPI_DATA_O = tx_reg[7];
	assign SPI_DATA_OE_O = oe_reg;
	assign HIGH_SIDE_ON_O = high_reg;
	assign LOW_SIDE_ON_O = low_reg;
	assign PWM_SOURCE_O = pwm_reg;

	sequence s_write(logic [2:0] s);
		wr_en && wr_sel == s;
	endsequence

	property p_reset_zero;
		@(posedge CLOCK_I) $past(RST_I) && !RST_I |->
			sw_lo_reg == 8'h00 && sw_hi_reg == 8'h00 && mode_reg == 8'h00;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("reset value not zero");

	property p_frame_len;
		@(posedge CLOCK_I) disable iff (RST_I)
		commit |-> bit_cnt_reg == 5'h10;
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("commit without 16 bits");

	property p_no_self_change;
		@(posedge CLOCK_I) disable iff (RST_I)
		!wr_en |=> $stable({sw_lo_reg, sw_hi_reg, mode_reg});
	endproperty
	a_no_self_change: assert property (p_no_self_change)
		else $error("register changed without write");

	property p_read_only;
		@(posedge CLOCK_I) disable iff (RST_I)
		commit && !rx_reg[15] |=> $stable({sw_lo_reg, sw_hi_reg, mode_reg});
	endproperty
	a_read_only: assert property (p_read_only)
		else $error("read altered a register");

	property p_write_lower;
		@(posedge CLOCK_I) disable iff (RST_I)
		s_write(3'h1) |=> sw_lo_reg == $past(rx_reg[7:0]);
	endproperty
	a_write_lower: assert property (p_write_lower)
		else $error("lower switch write lost");

	property p_write_upper;
		@(posedge CLOCK_I) disable iff (RST_I)
		s_write(3'h2) |=> sw_hi_reg == $past(rx_reg[7:0]) ##1 HIGH_SIDE_ON_O[7] ==
			(sw_hi_reg[7] & ~sw_hi_reg[6]);
	endproperty
	a_write_upper: assert property (p_write_upper)
		else $error("upper switch write lost");

	property p_write_mode;
		@(posedge CLOCK_I) disable iff (RST_I)
		s_write(3'h4) |=> ##1 PWM_SOURCE_O == $past(rx_reg[7:0], 2);
	endproperty
	a_write_mode: assert property (p_write_mode)
		else $error("mode write not shown");

	property p_readback;
		@(posedge CLOCK_I) disable iff (RST_I)
		load_tx && rd_sel[0] |=> SPI_DATA_O == sw_lo_reg[7];
	endproperty
	a_readback: assert property (p_readback)
		else $error("read returned wrong bit");

	property p_cross_block;
		@(posedge CLOCK_I) disable iff (RST_I)
		1'b1 |=> HIGH_SIDE_ON_O == ($past(high_want) & ~$past(low_want))
			&& LOW_SIDE_ON_O == ($past(low_want) & ~$past(high_want));
	endproperty
	a_cross_block: assert property (p_cross_block)
		else $error("bridge drive wrong");

	// output-side guard, independent of how the drive terms are built
	property p_no_cross;
		@(posedge CLOCK_I) disable iff (RST_I)
		(HIGH_SIDE_ON_O & LOW_SIDE_ON_O) == 8'h00;
	endproperty
	a_no_cross: assert property (p_no_cross)
		else $error("both switches of a bridge on");
endmodule
`default_nettype wire

// *** half_bridge_ctrl_regs_tb.sv ***
// self-checking bench of the half-bridge control register bank
`timescale 1ns/1ns
`default_nettype none
module half_bridge_ctrl_regs_tb;
	logic clock, rst, cs_n, sclk, mosi, miso_out, miso_oe;
	wire miso;
	logic [7:0] high_on, low_on, pwm, rdv, lo, up, pm;
	int num_errors = 0;
	int n_compared = 0;
	assign miso = miso_oe ? miso_out : 1'bz;
	half_bridge_ctrl_regs u_half_bridge_ctrl_regs (
		.CLOCK_I(clock), .RST_I(rst),
		.SPI_CS_N_I(cs_n), .SPI_CLK_I(sclk), .SPI_DATA_I(mosi),
		.SPI_DATA_O(miso_out), .SPI_DATA_OE_O(miso_oe),
		.HIGH_SIDE_ON_O(high_on), .LOW_SIDE_ON_O(low_on), .PWM_SOURCE_O(pwm)
	);
	spi_host_model u_spi_host_model (
		.cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso)
	);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic end_of_test;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		n_compared++;
		if (seen !== want) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
		end
	endtask
	// a bridge with both bits set stays off on both sides
	function automatic logic [3:0] side(input logic [7:0] r, input bit hi);
		for (int k = 0; k < 4; k++)
			side[k] = hi ? r[2*k+1] & ~r[2*k] : r[2*k] & ~r[2*k+1];
	endfunction
	task automatic settle;
		repeat (8) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_spi_host_model.frame({1'b1, a[6:0], d}, 16, rdv);
		settle();
	endtask
	// data byte of a read is all ones; it must not be stored
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
		u_spi_host_model.frame({1'b0, a[6:0], 8'hFF}, 16, rdv);
		chk(rdv, want);
		settle();
	endtask
	task automatic outs;
		chk(high_on, {side(up, 1'b1), side(lo, 1'b1)});
		chk(low_on, {side(up, 1'b0), side(lo, 1'b0)});
		chk(pwm, pm);
		// between frames the data line must be released
		chk({7'h00, miso_oe}, 8'h00);
	endtask
	initial begin
		#200000;
		num_errors++;
		end_of_test();
	end
	initial begin
		rst = 1'b1;
		lo = 8'h00;
		up = 8'h00;
		pm = 8'h00;
		repeat (5) @(posedge clock);
		#1;
		rst = 1'b0;
		settle();
		outs();
		rd_chk(8'h01, 8'h00);
		rd_chk(8'h41, 8'h00);
		rd_chk(8'h61, 8'h00);
		lo = 8'hB4;
		wr(8'h01, lo);
		up = 8'h6D;
		wr(8'h43, up);
		pm = 8'hE4;
		wr(8'h61, pm);
		outs();
		rd_chk(8'h03, lo);
		rd_chk(8'h41, up);
		rd_chk(8'h61, pm);
		wr(8'h05, 8'hFF);
		wr(8'h00, 8'hFF);
		wr(8'h51, 8'hFF);
		rd_chk(8'h05, 8'h00);
		u_spi_host_model.frame({8'h81, 8'h00}, 15, rdv);
		settle();
		u_spi_host_model.frame({8'h81, 8'h00}, 17, rdv);
		settle();
		outs();
		rd_chk(8'h01, lo);
		rst = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		rst = 1'b0;
		lo = 8'h00;
		up = 8'h00;
		pm = 8'h00;
		settle();
		outs();
		rd_chk(8'h41, 8'h00);
		end_of_test();
	end
endmodule
`default_nettype wire

// *** hb_regs_pkg.sv ***
// constants of the half-bridge control register bank
// Summary of operation
// - After reset every control register holds 8'h00.
// - A serial command is sixteen bits: an address byte then a data byte.
// - The device never changes a control bit on its own; only a write does.
// - With address bit 7 high, the data byte is stored in the register.
// - Registers read back the last value written, or the reset value.
// - The lower switch register sits at bits 6:4 = 000, 3:2 = 00, 0 = 1.
// - Bit 2k+1 is high side and bit 2k low side of bridge k+1.
// - An enable bit at zero leaves its switch off, at one turns it on.
// - The upper switch register sits at bits 6:4 = 100, same layout.
// - Both enables of one bridge set turn both of its switches off.
// - The lower PWM source register sits at bits 6:4 = 110.
// - Two-bit fields pick the source of bridges 4 to 1, high to low.
// - Field code 00 is steady drive, 01 to 11 pick PWM channels 1 to 3.
package hb_regs_pkg;
	localparam int FRAME_BITS = 16;
	localparam int BYTE_BITS = 8;
	localparam int BRIDGES = 8;
	localparam int BRIDGES_PER_REG = 4;
	localparam int WRITE_FLAG_POS = 7;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [2:0] SEL_SWITCH_LOWER = 3'h0;
	localparam logic [2:0] SEL_SWITCH_UPPER = 3'h4;
	localparam logic [2:0] SEL_PWM_LOWER = 3'h6;
	localparam logic [1:0] SEL_MIDDLE = 2'h0;
	localparam logic SEL_TAG = 1'h1;
	localparam logic [1:0] MODE_STEADY = 2'h0;
	localparam logic [1:0] MODE_PWM1 = 2'h1;
	localparam logic [1:0] MODE_PWM2 = 2'h2;
	localparam logic [1:0] MODE_PWM3 = 2'h3;
	localparam logic [4:0] ADDR_LAST_BIT = 5'h07;
	localparam logic [4:0] DATA_FIRST_BIT = 5'h08;
	localparam logic [4:0] DATA_LAST_BIT = 5'h0F;
	localparam logic [2:0] PIN_RESET = 3'h4;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ADDR = 5'h02,
		ST_DATA = 5'h04,
		ST_FULL = 5'h08,
		ST_OVER = 5'h10
	} frame_state_e;
endpackage

// *** pin_sync.sv ***
// two-stage synchroniser for asynchronous serial pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] d_i,
	output var logic [WIDTH-1:0] q_o
);
	generate
		for (genvar i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_reg;
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					meta_reg <= RESET_VALUE[i];
					q_o[i] <= RESET_VALUE[i];
				end else begin
					meta_reg <= d_i[i];
					q_o[i] <= meta_reg;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// *** spi_host_model.sv ***
// serial host model that sends command frames to the register bank
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	output var logic cs_n_o,
	output var logic sclk_o,
	output var logic mosi_o,
	input wire logic miso_i
);
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
	end
	// nbits other than 16 makes a frame the bank has to drop
	task automatic frame(input logic [15:0] cmd, input int nbits,
		output logic [7:0] rd);
		rd = 8'h00;
		cs_n_o = 1'b0;
		#80;
		for (int i = 0; i < nbits; i++) begin
			mosi_o = cmd[15 - (i % 16)];
			#80;
			sclk_o = 1'b1;
			if (i >= 8 && i < 16) begin
				rd = {rd[6:0], miso_i};
			end
			#80;
			sclk_o = 1'b0;
		end
		#80;
		cs_n_o = 1'b1;
		// released line flips so a stale level never passes for data
		mosi_o = ~mosi_o;
		#80;
	endtask
endmodule
`default_nettype wire
